// *** verilog/owd_pkg.sv ***
// package of constants and types for the option byte watchdog
package owd_pkg;

  localparam logic [7:0] ADDR_REFRESH = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_MASK    = 8'h08;
  localparam logic [7:0] ADDR_COUNT   = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG  = 8'hc0;

  localparam logic [7:0] REFRESH_KEY  = 8'hac;
  localparam logic [1:0] WIN_FULL     = 2'b11;
  localparam logic [1:0] WIN_HALF     = 2'b01;

  localparam int          STAT_INTERVAL = 0;
  localparam logic [31:0] STAT_RESET    = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET    = 32'h0000_0000;

  // low-speed oscillator derived from the system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int LS_PERIOD_NS  = 30518;
  localparam int LS_DIV        = LS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LS_QUARTER    = LS_DIV / 4;

  localparam int CNT_W = 18;

  typedef struct packed
  {
    logic       irq_en;
    logic [1:0] win_sel;
    logic       run_en;
    logic [2:0] ovf_sel;
    logic       stby_run;
  } owd_cfg_type;

  typedef struct packed
  {
    logic       sel;
    logic       enable;
    logic       write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } owd_apb_type;

  // overflow period in low-speed ticks
  function automatic logic [CNT_W-1:0] ovf_ticks(input logic [2:0] sel);
    logic [CNT_W-1:0] r;
    r = 18'h00080;
    unique case (sel)
      3'h0: r = 18'h00080;
      3'h1: r = 18'h00100;
      3'h2: r = 18'h00200;
      3'h3: r = 18'h00400;
      3'h4: r = 18'h01000;
      3'h5: r = 18'h04000;
      3'h6: r = 18'h08000;
      3'h7: r = 18'h20000;
    endcase
    return r;
  endfunction

endpackage

// *** verilog/owd_watchdog.sv ***
// watchdog timer configured by a byte latched at reset release
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
module owd_watchdog
(
  input  wire logic        clk_sys,      // 100 mhz system clock
  input  wire logic        rstn,         // async reset, active low
  input  wire logic [7:0]  option_byte,  // configuration byte from flash
  input  wire logic        standby_mode, // halt, stop or snooze active
  input  wire logic        bit_op_write, // current write is a bit instruction
  input  wire logic        illegal_access_detect_sw, // software detector enable
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb enable
  input  wire logic        pwrite,       // apb direction
  input  wire logic [31:0] paddr,        // apb address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic [31:0]      prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error
  output logic             wdt_reset,    // internal reset request
  output logic             interval_irq, // masked interrupt
  output logic             illegal_access_detect_enable // detector enable
);

  owd_pkg::owd_cfg_type cfg_q;
  owd_pkg::owd_apb_type bus;
  logic                 loaded_q;
  logic [11:0]          div_q;
  logic [owd_pkg::CNT_W-1:0] cnt_q;
  logic [31:0]          status_q;
  logic [31:0]          mask_q;
  logic                 rst_q;
  logic [31:0]          rdata_q;

  assign bus = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr[7:0], wdata: pwdata};

  // address decode
  wire hi_zero   = (paddr[31:8] == 24'h000000);
  wire hit_ref   = hi_zero && (bus.addr == owd_pkg::ADDR_REFRESH);
  wire hit_stat  = hi_zero && (bus.addr == owd_pkg::ADDR_STATUS);
  wire hit_mask  = hi_zero && (bus.addr == owd_pkg::ADDR_MASK);
  wire hit_cnt   = hi_zero && (bus.addr == owd_pkg::ADDR_COUNT);
  wire hit_cfg   = hi_zero && (bus.addr == owd_pkg::ADDR_CONFIG);
  wire mapped    = hit_ref | hit_stat | hit_mask | hit_cnt | hit_cfg;
  wire access    = bus.sel & bus.enable;
  wire wr        = access & bus.write & mapped;
  wire rd        = access & ~bus.write & mapped;

  // low-speed tick and its quarter point
  wire ls_tick    = (div_q == 12'(owd_pkg::LS_DIV - 1));
  wire ls_quarter = (div_q == 12'(owd_pkg::LS_QUARTER));

  wire [owd_pkg::CNT_W-1:0] ovf  = owd_pkg::ovf_ticks(cfg_q.ovf_sel);
  wire [owd_pkg::CNT_W-1:0] half = ovf >> 1;
  wire [owd_pkg::CNT_W-1:0] tq   = (ovf >> 1) + (ovf >> 2);

  wire stall    = standby_mode & ~cfg_q.stby_run;
  wire running  = loaded_q & cfg_q.run_en & ~rst_q & ~stall;

  wire full_win = ~cfg_q.stby_run | (cfg_q.win_sel == owd_pkg::WIN_FULL);
  wire win_open = full_win | (cnt_q >= half);

  wire ref_wr   = wr & hit_ref & loaded_q & cfg_q.run_en;
  wire ref_good = ref_wr & ~bit_op_write & win_open &
                  (bus.wdata[7:0] == owd_pkg::REFRESH_KEY);
  wire ref_bad  = ref_wr & ~ref_good;
  wire overflow = running & ls_tick & (cnt_q == ovf - 18'h00001);
  wire fault    = ref_bad | overflow;

  wire iv_event = running & cfg_q.irq_en & ls_quarter & (cnt_q == tq);

  wire stat_clr = wr & hit_stat;
  wire [31:0] iv_set  = {31'h0, iv_event};
  wire [31:0] stat_d  = (status_q & ~(stat_clr ? bus.wdata : 32'h0)) | iv_set;

  wire [31:0] rd_mux =
    hit_stat ? status_q :
    hit_mask ? mask_q :
    hit_cnt  ? {14'h0, cnt_q} :
    hit_cfg  ? {24'h0, cfg_q} : 32'h0;

  // configuration capture after reset release
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      loaded_q <= 1'b0;
      cfg_q    <= '0;
    end
    else if (!loaded_q)
    begin
      loaded_q <= 1'b1;
      cfg_q    <= option_byte;
    end
  end

  // low-speed divider, restarted by a refresh
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      div_q <= 12'h000;
    else if (ref_good || (running && ls_tick))
      div_q <= 12'h000; // a tick met in standby is held, not lost
    else if (running)
      div_q <= div_q + 12'h001;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      cnt_q <= '0;
    else if (ref_good || overflow)
      cnt_q <= '0;
    else if (running && ls_tick)
      cnt_q <= cnt_q + 18'h00001;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_q <= 1'b0;
    else if (fault)
      rst_q <= 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      status_q <= owd_pkg::STAT_RESET;
      mask_q   <= owd_pkg::MASK_RESET;
    end
    else
    begin
      status_q <= stat_d & 32'h0000_0001;
      if (wr && hit_mask)
        mask_q <= bus.wdata & 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 32'h0;
    else if (bus.sel && !bus.enable && !bus.write)
      rdata_q <= rd_mux;
  end

  assign prdata  = rd ? rdata_q : 32'h0;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign wdt_reset    = rst_q;
  assign interval_irq = |(status_q & mask_q);
  assign illegal_access_detect_enable =
    (loaded_q & cfg_q.run_en) | illegal_access_detect_sw;

  // checks
  sequence s_key_write;
    ref_good;
  endsequence

  sequence s_cleared;
    (cnt_q == '0) && !rst_q;
  endsequence

  a_key_clears_count: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_key_write |=> s_cleared)
    else $error("refresh did not clear the counter");

  a_fault_sets_reset: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    fault |=> wdt_reset [*3])
    else $error("fault did not hold reset");

  a_overflow_reset: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (running && ls_tick && cnt_q == ovf - 18'h00001) |=> wdt_reset)
    else $error("overflow did not reset");

  a_bitop_reset: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (wr && hit_ref && loaded_q && cfg_q.run_en && bit_op_write) |=> wdt_reset)
    else $error("bit write to refresh did not reset");

  a_bad_key_reset: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (ref_wr && pwdata[7:0] != owd_pkg::REFRESH_KEY) |=> wdt_reset)
    else $error("wrong key did not reset");

  a_closed_win_reset: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (ref_wr && cfg_q.stby_run && cfg_q.win_sel == owd_pkg::WIN_HALF && cnt_q < half)
    |=> wdt_reset)
    else $error("closed window write did not reset");

  a_interval_gate: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $rose(status_q[0]) |-> $past(cfg_q.irq_en) && $past(cnt_q) == $past(tq))
    else $error("interval flag at wrong point");

  a_stopped_hold: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (loaded_q && !cfg_q.run_en) |=> cnt_q == '0)
    else $error("counter moved while disabled");

  a_standby_hold: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (loaded_q && stall) |=> $stable(cnt_q))
    else $error("counter moved in standby");

  a_cfg_stable: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $past(loaded_q) |-> $stable(cfg_q))
    else $error("configuration changed after load");

  a_detect_forced: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (loaded_q && cfg_q.run_en) |-> illegal_access_detect_enable)
    else $error("detector not forced on");

  sequence s_clean_refresh;
    ref_wr && !rst_q && !overflow && !bit_op_write &&
    (pwdata[7:0] == owd_pkg::REFRESH_KEY);
  endsequence

  a_div_restart: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_key_write |=> div_q == 12'h000)
    else $error("refresh did not restart the divider");

  a_reset_sticky: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    wdt_reset |=> wdt_reset)
    else $error("reset request dropped before reset");

  a_count_bound: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    loaded_q |-> cnt_q < ovf)
    else $error("counter passed the overflow count");

  a_count_step: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (running && ls_tick && !ref_good && !overflow) |=> cnt_q == $past(cnt_q) + 18'h00001)
    else $error("counter did not step on a tick");

  a_count_idle: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (running && !ls_tick && !ref_good) |=> $stable(cnt_q))
    else $error("counter moved between ticks");

  a_no_irq_off: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (loaded_q && !cfg_q.irq_en) |=> !status_q[owd_pkg::STAT_INTERVAL])
    else $error("interval flag set while disabled");

  a_irq_masked: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    interval_irq |-> cfg_q.irq_en && mask_q[owd_pkg::STAT_INTERVAL])
    else $error("interrupt without enabled interval flag");

  a_full_win_ok: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_clean_refresh ##0 (!cfg_q.stby_run) |=> !wdt_reset)
    else $error("refresh refused with standby bit clear");

  a_sel_full_ok: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_clean_refresh ##0 (cfg_q.win_sel == owd_pkg::WIN_FULL) |=> !wdt_reset)
    else $error("refresh refused with full window");

  a_half_open_ok: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s_clean_refresh ##0 (cnt_q >= half) |=> !wdt_reset)
    else $error("refresh refused in the open window");

  a_stopped_quiet: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (loaded_q && !cfg_q.run_en) |=> !wdt_reset)
    else $error("reset raised while counter disabled");

  a_cfg_loaded: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $rose(loaded_q) |-> cfg_q == $past(option_byte))
    else $error("configuration not taken from the option byte");

endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the option byte watchdog
`timescale 1ns/1ns
module tb_top;
  localparam int TICK_WAIT = owd_pkg::LS_DIV + owd_pkg::LS_DIV / 2;
  logic                 clk_sys      = 1'b0;
  logic                 rstn         = 1'b0;
  logic [7:0]           option_byte  = 8'h00;
  logic                 standby_mode = 1'b0;
  logic                 bit_op_write = 1'b0;
  logic                 det_sw       = 1'b0;
  owd_pkg::owd_apb_type bus          = '0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 wdt_reset;
  logic                 interval_irq;
  logic                 det_en;
  logic [31:0]          rd;
  logic                 er;
  int                   err_total    = 0;
  int                   num_checks   = 0;
  logic [7:0]           cfgs[4]      = '{8'h31, 8'h71, 8'h71, 8'h61};
  logic [7:0]           keys[4]      = '{8'hac, 8'h55, 8'hac, 8'h55};
  logic                 bops[4]      = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic                 exps[4]      = '{1'b1, 1'b1, 1'b1, 1'b0};

  owd_watchdog i_dut
  (
    .clk_sys                      (clk_sys),
    .rstn                         (rstn),
    .option_byte                  (option_byte),
    .standby_mode                 (standby_mode),
    .bit_op_write                 (bit_op_write),
    .illegal_access_detect_sw     (det_sw),
    .psel                         (bus.sel),
    .penable                      (bus.enable),
    .pwrite                       (bus.write),
    .paddr                        ({24'h0, bus.addr}),
    .pwdata                       (bus.wdata),
    .prdata                       (prdata),
    .pready                       (pready),
    .pslverr                      (pslverr),
    .wdt_reset                    (wdt_reset),
    .interval_irq                 (interval_irq),
    .illegal_access_detect_enable (det_en)
  );

  always #5 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic bop);
    int n;
    n = 0;
    @(posedge clk_sys);
    bus <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: addr, wdata: data};
    bit_op_write <= bop;
    @(posedge clk_sys);
    bus.enable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      n++;
      @(posedge clk_sys);
    end
    rd = prdata;
    er = pslverr;
    check(n, 0, "pready");
    bus <= '0;
    bit_op_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, addr, 32'h0, 1'b0);
    check(rd, exp, "read data");
    check({31'h0, er}, {31'h0, exp_err}, "slave error");
  endtask

  task automatic boot(input logic [7:0] cfg);
    rstn <= 1'b0;
    option_byte <= cfg;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  initial
  begin
    boot(8'h71);
    option_byte <= 8'h00;
    rd_chk(owd_pkg::ADDR_CONFIG, 32'h0000_0071, 1'b0);
    rd_chk(owd_pkg::ADDR_STATUS, owd_pkg::STAT_RESET, 1'b0);
    rd_chk(owd_pkg::ADDR_MASK, owd_pkg::MASK_RESET, 1'b0);
    rd_chk(8'h10, 32'h0, 1'b1);
    check({31'h0, det_en}, 32'h1, "detector forced on");
    apb(1'b1, owd_pkg::ADDR_MASK, 32'h1, 1'b0);
    rd_chk(owd_pkg::ADDR_MASK, 32'h1, 1'b0);
    check({31'h0, interval_irq}, 32'h0, "irq idle");
    apb(1'b1, owd_pkg::ADDR_REFRESH, {24'h0, owd_pkg::REFRESH_KEY}, 1'b0);
    standby_mode <= 1'b1;
    repeat (TICK_WAIT) @(posedge clk_sys);
    rd_chk(owd_pkg::ADDR_COUNT, 32'h1, 1'b0);
    apb(1'b1, owd_pkg::ADDR_REFRESH, {24'h0, owd_pkg::REFRESH_KEY}, 1'b0);
    rd_chk(owd_pkg::ADDR_COUNT, 32'h0, 1'b0);
    check({31'h0, wdt_reset}, 32'h0, "no reset on good key");
    $display("test base done");
    // standby run off: counter halts, window forced full
    boot(8'h30);
    apb(1'b1, owd_pkg::ADDR_REFRESH, {24'h0, owd_pkg::REFRESH_KEY}, 1'b0);
    repeat (TICK_WAIT) @(posedge clk_sys);
    rd_chk(owd_pkg::ADDR_COUNT, 32'h0, 1'b0);
    check({31'h0, wdt_reset}, 32'h0, "early refresh in full window");
    $display("test standby done");
    standby_mode <= 1'b0;
    det_sw <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      boot(cfgs[i]);
      apb(1'b1, owd_pkg::ADDR_REFRESH, {24'h0, keys[i]}, bops[i]);
      repeat (4) @(posedge clk_sys);
      check({31'h0, wdt_reset}, {31'h0, exps[i]}, "reset request");
      check({31'h0, det_en}, 32'h1, "detector enable");
    end
    det_sw <= 1'b0;
    @(posedge clk_sys);
    check({31'h0, det_en}, 32'h0, "detector follows software");
    repeat (TICK_WAIT) @(posedge clk_sys);
    rd_chk(owd_pkg::ADDR_COUNT, 32'h0, 1'b0);
    $display("test malfunction done");
    final_report();
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
endmodule
